/* src/sdt_pkg.sv */
package sdt_pkg;
   localparam int          WORD_W        = 10;   // encoded word width
   localparam int          BITS_PER_CYC  = 2;    // ddr: two bits per half-bit-rate cycle
   localparam int          CYC_PER_WORD  = 5;    // word = five half-bit-rate cycles
   localparam int          BITCLK_RATIO  = 10;   // bit clock vs word clock
   localparam int          CLK_MULT      = 5;    // synthesizer multiply factor
   localparam int          FIFO_DEPTH    = 8;
   localparam int          REF_MHZ_SD    = 27;
   localparam int          REF_MHZ_360   = 36;
   localparam int          REF_MHZ_2X    = 54;
   localparam int          HALF_MHZ_SD   = REF_MHZ_SD * CLK_MULT;   // 135
   localparam int          HALF_MHZ_360  = REF_MHZ_360 * CLK_MULT;  // 180
   localparam int          FULL_MHZ_2X   = REF_MHZ_2X * CLK_MULT;   // 270
   localparam logic [2:0]  PHASE_LAST    = 3'h4;
   localparam logic [2:0]  PHASE_FIRST   = 3'h0;
   typedef enum logic [1:0] {
      SDT_IDLE = 2'b00,
      SDT_SHIFT = 2'b01
   } sdt_state_t;
endpackage

/* src/sdt_fifo.sv */
`timescale 1ns/1ps
module sdt_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_reg [D];
   logic [AW:0]  wr_reg;
   logic [AW:0]  rd_reg;
   logic [W-1:0] dout_reg;
   logic         dval_reg;
   wire          full_w  = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
   wire          empty_w = (wr_reg == rd_reg);
   wire          push_w  = in_valid_i && !full_w;
   // read into output register whenever it is empty or being drained
   wire          pop_w   = !empty_w && (!dval_reg || out_ready_i);
   assign in_ready_o  = !full_w;
   assign out_data_o  = dout_reg;
   assign out_valid_o = dval_reg;
   always_ff @(posedge clk_i) begin
      if (push_w) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_reg   <= '0;
         rd_reg   <= '0;
         dout_reg <= '0;
         dval_reg <= 1'b0;
      end else begin
         if (push_w) wr_reg <= wr_reg + 1'b1;
         if (pop_w) begin
            rd_reg   <= rd_reg + 1'b1;
            dout_reg <= mem_reg[rd_reg[AW-1:0]];
            dval_reg <= 1'b1;
         end else if (out_ready_i) begin
            dval_reg <= 1'b0;
         end
      end
   end
endmodule

/* src/sdt_serializer.sv */
`timescale 1ns/1ps
module sdt_serializer #(
   parameter int WORD_W     = sdt_pkg::WORD_W,
   parameter int FIFO_DEPTH = sdt_pkg::FIFO_DEPTH
) (
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   input  wire logic              word_clk_i,
   input  wire logic [WORD_W-1:0] word_data_i,
   input  wire logic              word_valid_i,
   output logic                   word_ready_o,
   output logic                   load_strobe_o,
   output logic                   underrun_o,
   output logic                   ddr_in_rise_o,
   output logic                   ddr_in_fall_o
);
   // clk_i is the synthesized half-bit-rate clock: word clock times five from
   // a single multiplier (135/180 MHz), or 54 MHz times five for 270 MHz;
   // two multipliers in series would stack their jitter
   logic              wclk_s1_reg;
   logic              wclk_s2_reg;
   logic              wclk_d_reg;
   logic [2:0]        phase_reg;
   logic              locked_reg;
   logic [WORD_W-1:0] shift_reg;
   logic              rise_reg;
   logic              fall_reg;
   logic              strobe_reg;
   logic              under_reg;
   sdt_pkg::sdt_state_t state_reg;
   wire [WORD_W-1:0]  fifo_data_w;
   wire               fifo_valid_w;

   wire wclk_rise_w  = wclk_s2_reg && !wclk_d_reg;
   // load two cycles after the word clock edge is first sampled, then free-run one in five
   wire load_w = wclk_rise_w || (locked_reg && (phase_reg == sdt_pkg::PHASE_LAST));
   wire pop_w  = load_w;
   // word captured on load; an empty fifo gives the all-zero fill word
   wire [WORD_W-1:0] load_word_w = fifo_valid_w ? fifo_data_w : '0;

   // words arrive upstream already scrambled and NRZI coded
   sdt_fifo #(
      .W (WORD_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .in_data_i   (word_data_i),
      .in_valid_i  (word_valid_i),
      .in_ready_o  (word_ready_o),
      .out_data_o  (fifo_data_w),
      .out_valid_o (fifo_valid_w),
      .out_ready_i (pop_w)
   );

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wclk_s1_reg <= 1'b0;
         wclk_s2_reg <= 1'b0;
         wclk_d_reg  <= 1'b0;
      end else begin
         wclk_s1_reg <= word_clk_i;
         wclk_s2_reg <= wclk_s1_reg;
         wclk_d_reg  <= wclk_s2_reg;
      end
   end

   // phase counter: five half-bit-rate cycles equal ten bit times per word
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_reg  <= sdt_pkg::PHASE_FIRST;
         locked_reg <= 1'b0;
      end else if (load_w) begin
         phase_reg  <= sdt_pkg::PHASE_FIRST;
         locked_reg <= 1'b1;
      end else begin
         phase_reg  <= phase_reg + 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg  <= sdt_pkg::SDT_IDLE;
         shift_reg  <= '0;
         rise_reg   <= 1'b0;
         fall_reg   <= 1'b0;
         strobe_reg <= 1'b0;
         under_reg  <= 1'b0;
      end else begin
         strobe_reg <= load_w;
         if (load_w) begin
            // empty fifo sends zeros; a stalled link is worse than a bad word
            shift_reg <= load_word_w;
            under_reg <= !fifo_valid_w;
            state_reg <= sdt_pkg::SDT_SHIFT;
         end else begin
            shift_reg <= shift_reg >> sdt_pkg::BITS_PER_CYC;
         end
         unique case (state_reg)
            sdt_pkg::SDT_IDLE: begin
               // the very first load must already launch its first pair
               fall_reg <= load_w ? load_word_w[0] : 1'b0;
               rise_reg <= load_w ? load_word_w[1] : 1'b0;
            end
            sdt_pkg::SDT_SHIFT: begin
               // lsb goes to the input launched first in the period
               fall_reg <= load_w ? load_word_w[0] : shift_reg[2];
               rise_reg <= load_w ? load_word_w[1] : shift_reg[3];
            end
         endcase
      end
   end

   assign load_strobe_o = strobe_reg;
   assign underrun_o    = under_reg;
   assign ddr_in_rise_o = rise_reg;
   assign ddr_in_fall_o = fall_reg;
endmodule

/* tb/sdt_chk.sv */
`timescale 1ns/1ps
module sdt_chk (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic word_clk_i,
   input wire logic word_valid_i,
   input wire logic word_ready_o,
   input wire logic load_strobe_o,
   input wire logic underrun_o,
   input wire logic ddr_in_rise_o,
   input wire logic ddr_in_fall_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic [3:0] arm_reg;
   // spacing only judged once the first resync has settled
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i) arm_reg <= 4'h0;
      else if (arm_reg != 4'hf && (arm_reg != 4'h0 || $rose(word_clk_i))) arm_reg <= arm_reg + 4'h1;
   sequence s_gap; !load_strobe_o [*4] ##1 load_strobe_o; endsequence
   property p_gap; load_strobe_o && arm_reg == 4'hf |=> s_gap; endproperty
   a_gap: assert property (p_gap) else $error("strobe spacing wrong");
   property p_sync; $rose(word_clk_i) |-> ##[3:5] load_strobe_o; endproperty
   a_sync: assert property (p_sync) else $error("no load after word clock");
   property p_pulse; load_strobe_o |=> !load_strobe_o; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
   property p_zero; underrun_o |-> !ddr_in_rise_o && !ddr_in_fall_o; endproperty
   a_zero: assert property (p_zero) else $error("bits sent on underrun");
   property p_urun; $changed(underrun_o) |-> load_strobe_o; endproperty
   a_urun: assert property (p_urun) else $error("underrun moved off load");
   property p_hold; arm_reg == 4'hf && load_strobe_o && underrun_o |-> underrun_o [*5]; endproperty
   a_hold: assert property (p_hold) else $error("underrun not held");
   property p_full; $fell(word_ready_o) |-> $past(word_valid_i); endproperty
   a_full: assert property (p_full) else $error("ready fell without a take");
   property p_free; $rose(word_ready_o) |-> ##[0:1] load_strobe_o; endproperty
   a_free: assert property (p_free) else $error("ready rose off load");
endmodule
bind sdt_serializer sdt_chk u_chk (.clk_i, .rstn_i, .word_clk_i, .word_valid_i, .word_ready_o,
   .load_strobe_o, .underrun_o, .ddr_in_rise_o, .ddr_in_fall_o);

/* tb/sdt_drv_model.sv */
`timescale 1ns/1ps
module sdt_drv_model (
   input  wire logic       clk_i,
   input  wire logic       first_i,
   input  wire logic       second_i,
   input  wire logic       frame_i,
   output logic [9:0]      word_o,
   output logic            word_stb_o
);
   logic [9:0] sr = 10'h000;
   int         cnt = 0;
   // framing keyed to the strobe: cheaper than a boundary search
   always @(posedge clk_i) begin
      sr = {second_i, first_i, sr[9:2]};
      cnt = frame_i ? 1 : cnt + 1;
      word_o <= sr;
      word_stb_o <= (cnt == 5);
   end
endmodule

/* tb/sdt_serializer_tb.sv */
`timescale 1ns/1ps
module sdt_serializer_tb;
   logic       clk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic       word_clk_i = 1'b0;
   logic [9:0] word_data_i = 10'h000;
   logic       word_valid_i = 1'b0;
   logic       word_ready_o, load_strobe_o, underrun_o, ddr_in_rise_o, ddr_in_fall_o, rx_stb;
   logic [9:0] rx_word;
   logic [9:0] exp_q[$];
   int         n_errors = 0;
   int         n_compared = 0;
   int         k;
   logic       full_seen = 1'b0;
   logic       mon_on = 1'b1;
   // offered word, word expected back on the line; never zero, zero is idle fill
   logic [9:0] rows[4][2] = '{'{10'h001, 10'h001}, '{10'h200, 10'h200},
                              '{10'h155, 10'h155}, '{10'h3fe, 10'h3fe}};
   always #2.5 clk_i = ~clk_i;
   initial begin #1; forever #12.5 word_clk_i = ~word_clk_i; end
   sdt_serializer DUT (.clk_i, .rstn_i, .word_clk_i, .word_data_i, .word_valid_i, .word_ready_o,
      .load_strobe_o, .underrun_o, .ddr_in_rise_o, .ddr_in_fall_o);
   sdt_drv_model u_drv (.clk_i, .first_i(ddr_in_fall_o), .second_i(ddr_in_rise_o),
      .frame_i(load_strobe_o), .word_o(rx_word), .word_stb_o(rx_stb));
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic send(input logic [9:0] w, input logic [9:0] e);
      word_valid_i = 1'b1;
      word_data_i = w;
      for (k = 0; k < 40 && word_ready_o !== 1'b1; k++) begin
         full_seen = 1'b1;
         @(negedge clk_i);
      end
      if (k == 40) begin n_errors++; wrap_up(); end
      exp_q.push_back(e);
      @(negedge clk_i);
   endtask
   task automatic drain;
      word_valid_i = 1'b0;
      for (k = 0; k < 400 && exp_q.size() > 0; k++) @(negedge clk_i);
      if (k == 400) begin n_errors++; wrap_up(); end
      repeat (12) @(negedge clk_i);
      check({9'h000, underrun_o}, 10'h001);
   endtask
   always @(posedge clk_i)
      if (mon_on && rx_stb === 1'b1 && rx_word !== 10'h000) begin
         if (exp_q.size() == 0) check(rx_word, 10'h000);
         else check(rx_word, exp_q.pop_front());
      end
   task automatic reset_check;
      check({word_ready_o, load_strobe_o, underrun_o, ddr_in_rise_o, ddr_in_fall_o, 5'h00}, 10'h200);
   endtask
   initial begin
      repeat (11) @(negedge clk_i);
      reset_check();
      @(negedge clk_i);
      rstn_i = 1'b1;
      $display("test done: reset");
      for (int p = 0; p < 3; p++)
         for (int r = 0; r < 4; r++) send(rows[r][0] ^ 10'(p * 64), rows[r][1] ^ 10'(p * 64));
      check({9'h000, full_seen}, 10'h001);
      drain();
      $display("test done: rows");
      send(10'h2c3, 10'h2c3);
      mon_on = 1'b0;
      rstn_i = 1'b0;
      @(negedge clk_i);
      reset_check();
      exp_q.delete();
      rstn_i = 1'b1;
      send(10'h0a5, 10'h0a5);
      mon_on = 1'b1;
      send(10'h35a, 10'h35a);
      drain();
      $display("test done: reset mid-run");
      wrap_up();
   end
endmodule
